// file: src/isa_attr_decode.sv
// Address and permission decode of one coprocessor access
`timescale 1ns/1ps
`default_nettype none
module isa_attr_decode (
  input wire logic req_valid,
  input wire logic is_read,
  input wire logic [2:0] opc1,
  input wire logic [3:0] crn,
  input wire logic [3:0] secondary_register_number,
  input wire logic priv_mode,
  output logic hit,
  output logic grant,
  output logic deny
);
  wire logic addr_match;

  assign addr_match = (opc1 == isa_attr_pkg::BANK_OPC1) &&
                      (crn == isa_attr_pkg::BANK_PRIMARY) &&
                      (secondary_register_number == isa_attr_pkg::BANK_SECONDARY);
  assign hit = req_valid && addr_match;
  assign grant = hit && is_read && priv_mode;
  assign deny = hit && !(is_read && priv_mode);
endmodule
`default_nettype wire

// file: src/isa_attr_id_regs.sv
// Top of the attribute identification bank: decode, table and registered answer
// Functional notes
// - c0/c2 read returns attribute words
// - Opcode two 0..4 selects words ascending
// - Selections 5, 6, 7 read zero
// - Reads allowed in privileged mode only
// - 32-bit words of eight 4-bit fields
// - Word zero field values fixed
// - Word one field values fixed
// - Word two field values fixed
// - Word three field values fixed
// - Word four field values fixed
`timescale 1ns/1ps
`default_nettype none
module isa_attr_id_regs (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cp_req_valid,
  input wire logic cp_is_read,
  input wire logic [2:0] cp_opc1,
  input wire logic [3:0] cp_crn,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_opc2,
  input wire logic cp_priv_mode,
  output logic cp_resp_valid,
  output logic cp_hit,
  output logic cp_undef,
  output logic [31:0] cp_rdata
);
  wire logic hit;
  wire logic grant;
  wire logic deny;
  wire logic [31:0] rom_word;
  wire logic [31:0] rdata_d;
  wire logic resp_d;
  isa_attr_pkg::outcome_t outcome_d;

  logic resp_valid_q;
  logic hit_q;
  logic undef_q;
  logic [31:0] rdata_q;
  isa_attr_pkg::outcome_t outcome_q;

  isa_attr_decode u_decode (
    .req_valid(cp_req_valid),
    .is_read(cp_is_read),
    .opc1(cp_opc1),
    .crn(cp_crn),
    .secondary_register_number(cp_crm),
    .priv_mode(cp_priv_mode),
    .hit(hit),
    .grant(grant),
    .deny(deny)
  );

  isa_attr_rom u_rom (
    .sel(cp_opc2),
    .word(rom_word)
  );

  // Every request sampled out of reset gets an answer so the pipeline never waits on this bank
  assign resp_d = cp_req_valid;
  assign rdata_d = grant ? rom_word : isa_attr_pkg::READ_AS_ZERO;
  assign outcome_d = !cp_req_valid ? isa_attr_pkg::outcome_none :
                     !hit ? isa_attr_pkg::outcome_miss :
                     grant ? isa_attr_pkg::outcome_read : isa_attr_pkg::outcome_denied;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      resp_valid_q <= isa_attr_pkg::RESP_RESET;
      hit_q <= isa_attr_pkg::RESP_RESET;
      undef_q <= isa_attr_pkg::RESP_RESET;
      rdata_q <= isa_attr_pkg::RDATA_RESET;
      outcome_q <= isa_attr_pkg::outcome_none;
    end else begin
      resp_valid_q <= resp_d;
      hit_q <= hit;
      undef_q <= deny;
      rdata_q <= rdata_d;
      outcome_q <= outcome_d;
    end
  end

  assign cp_resp_valid = resp_valid_q;
  assign cp_hit = hit_q;
  assign cp_undef = undef_q;
  assign cp_rdata = rdata_q;

  // Access that addresses the bank, and its granted read, seen by checks only
  // Requests sampled in reset are dropped, so checks must drop them too
  wire logic chk_match;
  wire logic chk_grant;
  assign chk_match = reset_n && cp_req_valid && (cp_opc1 == 3'h0) && (cp_crn == 4'h0) &&
                     (cp_crm == 4'h2);
  assign chk_grant = chk_match && cp_is_read && cp_priv_mode;

  resp_timing_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (reset_n && cp_req_valid) |=> cp_resp_valid
  ) else $error("request without response");

  resp_cause_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    cp_resp_valid |-> $past(cp_req_valid)
  ) else $error("response without request");

  outcome_track_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    cp_resp_valid |-> ((outcome_q == isa_attr_pkg::outcome_read) == (cp_hit && !cp_undef))
  ) else $error("outcome and flags disagree");

  bank_read_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    chk_grant |=> (cp_resp_valid && cp_hit && !cp_undef)
  ) else $error("bank read not answered as a hit");

  bank_miss_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (reset_n && cp_req_valid && !chk_match) |=> (!cp_hit && !cp_undef && cp_rdata == 32'h0000_0000)
  ) else $error("foreign address claimed by bank");

  sel_order_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (chk_grant && cp_opc2 == 3'h1) |=> (cp_rdata[27:24] == 4'h2 && cp_rdata[3:0] == 4'h1)
  ) else $error("selector one picked wrong word");

  sel_reserved_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (chk_grant && cp_opc2 > 3'h4) |=> (cp_hit && cp_rdata == 32'h0000_0000)
  ) else $error("reserved selection read nonzero");

  priv_only_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (chk_match && cp_is_read && !cp_priv_mode) |=> (cp_undef && cp_rdata == 32'h0000_0000)
  ) else $error("unprivileged read not refused");

  word_fields_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (chk_grant && cp_opc2 == 3'h4) |=> (cp_rdata[31:16] == 16'h0000)
  ) else $error("reserved fields not zero");

  word_zero_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (chk_grant && cp_opc2 == 3'h0) |=>
      ({cp_rdata[23:20], cp_rdata[7:4], cp_rdata[3:0]} == 12'h111 &&
       {cp_rdata[31:24], cp_rdata[19:8]} == 20'h0_0000)
  ) else $error("word zero fields wrong");

  word_one_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (chk_grant && cp_opc2 == 3'h1) |=>
      ({cp_rdata[31:24], cp_rdata[15:12]} == 12'h122 &&
       cp_rdata[23:16] == 8'h00 && cp_rdata[11:0] == 12'h111)
  ) else $error("word one fields wrong");

  word_two_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (chk_grant && cp_opc2 == 3'h2) |=>
      (cp_rdata[31:16] == 16'h1122 && cp_rdata[15:12] == 4'h1 &&
       cp_rdata[11:8] == 4'h0 && cp_rdata[7:0] == 8'h11)
  ) else $error("word two fields wrong");

  word_three_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (chk_grant && cp_opc2 == 3'h3) |=>
      (cp_rdata[31:20] == 12'h011 && cp_rdata[19:16] == 4'h0 &&
       cp_rdata[15:8] == 8'h21 && cp_rdata[7:4] == 4'h3 && cp_rdata[3:0] == 4'h1)
  ) else $error("word three fields wrong");

  word_four_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (chk_grant && cp_opc2 == 3'h4) |=>
      (cp_rdata[15:12] == 4'h0 && cp_rdata[11:8] == 4'h1 &&
       cp_rdata[7:4] == 4'h4 && cp_rdata[3:0] == 4'h1)
  ) else $error("word four fields wrong");

  write_refused_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (chk_match && !cp_is_read) |=> (cp_hit && cp_undef && cp_rdata == 32'h0000_0000)
  ) else $error("write to constant bank not refused");

  read_stable_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (chk_grant ##1 (chk_grant && cp_opc2 == $past(cp_opc2))) |=>
      (cp_rdata == $past(cp_rdata))
  ) else $error("constant word changed between reads");

  reset_quiet_a: assert property (
    @(posedge mclk)
    !reset_n |=> (!cp_resp_valid && !cp_hit && !cp_undef && cp_rdata == 32'h0000_0000)
  ) else $error("outputs not cleared by reset");

  hit_resp_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    cp_hit |->
      cp_resp_valid
  ) else $error("hit flag without response");

  undef_hit_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    cp_undef |->
      (cp_hit && cp_resp_valid)
  ) else $error("refusal flag without bank hit");

  data_grant_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !(cp_resp_valid && cp_hit && !cp_undef) |->
      (cp_rdata == 32'h0000_0000)
  ) else $error("read data shown without granted read");

  idle_quiet_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (reset_n && !cp_req_valid) |=>
      (!cp_resp_valid && !cp_hit && !cp_undef)
  ) else $error("answer without request");

  user_write_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (chk_match && !cp_is_read && !cp_priv_mode) |=>
      (cp_hit && cp_undef && cp_rdata == 32'h0000_0000)
  ) else $error("unprivileged write not refused");

  user_reserved_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (chk_match && cp_is_read && !cp_priv_mode && cp_opc2 > 3'h4) |=>
      (cp_undef && cp_rdata == 32'h0000_0000)
  ) else $error("unprivileged reserved read not refused");

  low_field_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (chk_grant && cp_opc2 <= 3'h4) |=>
      (cp_rdata[3:0] == 4'h1)
  ) else $error("defined word lowest field wrong");

  zero_top_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (chk_grant && cp_opc2 == 3'h0) |=>
      (cp_rdata[31:28] == 4'h0)
  ) else $error("reserved field of word zero not zero");

  denied_flags_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (outcome_q == isa_attr_pkg::outcome_denied) |->
      (cp_hit && cp_undef && cp_rdata == 32'h0000_0000)
  ) else $error("denied access shows wrong flags");

  miss_flags_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (outcome_q == isa_attr_pkg::outcome_miss) |->
      (cp_resp_valid && !cp_hit && !cp_undef)
  ) else $error("foreign access shows wrong flags");

  none_flags_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (outcome_q == isa_attr_pkg::outcome_none) |->
      !cp_resp_valid
  ) else $error("response shown for idle cycle");

  read_flags_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (outcome_q == isa_attr_pkg::outcome_read) |->
      (cp_resp_valid && cp_hit && !cp_undef)
  ) else $error("granted read shows wrong flags");

  user_any_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (chk_match && !cp_priv_mode) |=>
      cp_undef
  ) else $error("unprivileged access not refused");

  reset_keep_a: assert property (
    @(posedge mclk)
    (!reset_n ##1 (chk_grant && cp_opc2 == 3'h4)) |=>
      (cp_rdata == 32'h0000_0141)
  ) else $error("word changed across reset");
endmodule
`default_nettype wire

// file: src/isa_attr_pkg.sv
// Constants for the instruction-set attribute identification bank
package isa_attr_pkg;
  localparam int WORD_W = 32;
  localparam int FIELD_W = 4;
  localparam int FIELD_N = 8;
  localparam int WORD_N = 5;
  localparam int SEL_W = 3;

  // Coprocessor register address of the bank
  localparam logic [2:0] BANK_OPC1 = 3'h0;
  localparam logic [3:0] BANK_PRIMARY = 4'h0;
  localparam logic [3:0] BANK_SECONDARY = 4'h2;

  // Secondary opcode selections
  localparam logic [2:0] SEL_WORD_ZERO = 3'h0;
  localparam logic [2:0] SEL_WORD_ONE = 3'h1;
  localparam logic [2:0] SEL_WORD_TWO = 3'h2;
  localparam logic [2:0] SEL_WORD_THREE = 3'h3;
  localparam logic [2:0] SEL_WORD_FOUR = 3'h4;
  localparam logic [2:0] SEL_LAST_VALID = 3'h4;

  // Hard-wired attribute words, eight 4-bit fields each
  // word zero to word four fields, then the read-as-zero word
  localparam logic [31:0] ISA_ATTR_WORD_ZERO = 32'h0010_0011;
  localparam logic [31:0] ISA_ATTR_WORD_ONE = 32'h1200_2111;
  localparam logic [31:0] ISA_ATTR_WORD_TWO = 32'h1122_1011;
  localparam logic [31:0] ISA_ATTR_WORD_THREE = 32'h0110_2131;
  localparam logic [31:0] ISA_ATTR_WORD_FOUR = 32'h0000_0141;
  localparam logic [31:0] READ_AS_ZERO = 32'h0000_0000;

  // Output values held during reset
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic RESP_RESET = 1'b0;

  // Cycles from an accepted request to its answer
  localparam int RESP_LATENCY = 1;

  // Outcome of one coprocessor access seen by this bank
  typedef enum logic [1:0] {
    outcome_none,
    outcome_read,
    outcome_denied,
    outcome_miss
  } outcome_t;
endpackage

// file: src/isa_attr_rom.sv
// Constant table of the five attribute words with read-as-zero holes
`timescale 1ns/1ps
`default_nettype none
module isa_attr_rom (
  input wire logic [2:0] sel,
  output logic [31:0] word
);
  localparam logic [31:0] TABLE [isa_attr_pkg::WORD_N] = '{
    isa_attr_pkg::ISA_ATTR_WORD_ZERO,
    isa_attr_pkg::ISA_ATTR_WORD_ONE,
    isa_attr_pkg::ISA_ATTR_WORD_TWO,
    isa_attr_pkg::ISA_ATTR_WORD_THREE,
    isa_attr_pkg::ISA_ATTR_WORD_FOUR
  };

  wire logic sel_valid;
  assign sel_valid = (sel <= isa_attr_pkg::SEL_LAST_VALID);

  genvar f;
  generate
    for (f = 0; f < isa_attr_pkg::FIELD_N; f = f + 1) begin : g_field
      wire logic [3:0] nib;
      assign nib = sel_valid ? TABLE[sel][f*isa_attr_pkg::FIELD_W +: isa_attr_pkg::FIELD_W]
                             : 4'h0;
      assign word[f*isa_attr_pkg::FIELD_W +: isa_attr_pkg::FIELD_W] = nib;
    end
  endgenerate
endmodule
`default_nettype wire

// file: verif/test_isa_attr_id_regs.sv
// Self-checking bench for the attribute identification bank
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module test_isa_attr_id_regs;
  logic mclk;
  logic reset_n;
  logic cp_req_valid;
  logic cp_is_read;
  logic [2:0] cp_opc1;
  logic [3:0] cp_crn;
  logic [3:0] cp_crm;
  logic [2:0] cp_opc2;
  logic cp_priv_mode;
  logic cp_resp_valid;
  logic cp_hit;
  logic cp_undef;
  logic [31:0] cp_rdata;
  int miscompares = 0;
  int cmp_count = 0;
  // Expected words by selection; the last three are reserved holes
  localparam logic [31:0] EXP_WORD [8] = '{32'h0010_0011, 32'h1200_2111, 32'h1122_1011,
    32'h0110_2131, 32'h0000_0141, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  isa_attr_id_regs u_dut (.mclk(mclk), .reset_n(reset_n), .cp_req_valid(cp_req_valid),
    .cp_is_read(cp_is_read), .cp_opc1(cp_opc1), .cp_crn(cp_crn), .cp_crm(cp_crm),
    .cp_opc2(cp_opc2), .cp_priv_mode(cp_priv_mode), .cp_resp_valid(cp_resp_valid),
    .cp_hit(cp_hit), .cp_undef(cp_undef), .cp_rdata(cp_rdata));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One access, answer checked one cycle later, then an idle cycle
  task automatic do_access(input logic rd, input logic [2:0] o1, input logic [3:0] n,
    input logic [3:0] m, input logic [2:0] o2, input logic pv, input logic h,
    input logic u, input logic [31:0] d);
    @(posedge mclk);
    cp_req_valid <= 1'b1;
    cp_is_read <= rd;
    cp_opc1 <= o1;
    cp_crn <= n;
    cp_crm <= m;
    cp_opc2 <= o2;
    cp_priv_mode <= pv;
    @(posedge mclk);
    cp_req_valid <= 1'b0;
    #1;
    `CHECK(cp_resp_valid, 1'b1)
    `CHECK(cp_hit, h)
    `CHECK(cp_undef, u)
    `CHECK(cp_rdata, d)
    @(posedge mclk);
    #1;
    `CHECK(cp_resp_valid, 1'b0)
    `CHECK(cp_rdata, 32'h0000_0000)
  endtask

  // Back-to-back privileged reads of all eight selections
  task automatic test_words();
    @(posedge mclk);
    cp_req_valid <= 1'b1;
    cp_is_read <= 1'b1;
    cp_opc1 <= 3'h0;
    cp_crn <= 4'h0;
    cp_crm <= 4'h2;
    cp_opc2 <= 3'h0;
    cp_priv_mode <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      cp_opc2 <= 3'(i + 1);
      if (i == 7) begin
        cp_req_valid <= 1'b0;
      end
      #1;
      `CHECK(cp_resp_valid, 1'b1)
      `CHECK(cp_hit, 1'b1)
      `CHECK(cp_rdata, EXP_WORD[i])
    end
    $display("test_words done");
  endtask

  // Writes and user-mode reads are refused, words stay intact
  task automatic test_refused();
    do_access(1'b0, 3'h0, 4'h0, 4'h2, 3'h1, 1'b1, 1'b1, 1'b1, 32'h0000_0000);
    do_access(1'b0, 3'h0, 4'h0, 4'h2, 3'h0, 1'b0, 1'b1, 1'b1, 32'h0000_0000);
    do_access(1'b1, 3'h0, 4'h0, 4'h2, 3'h3, 1'b0, 1'b1, 1'b1, 32'h0000_0000);
    do_access(1'b1, 3'h0, 4'h0, 4'h2, 3'h6, 1'b0, 1'b1, 1'b1, 32'h0000_0000);
    do_access(1'b1, 3'h0, 4'h0, 4'h2, 3'h1, 1'b1, 1'b1, 1'b0, 32'h1200_2111);
    do_access(1'b1, 3'h0, 4'h0, 4'h2, 3'h5, 1'b1, 1'b1, 1'b0, 32'h0000_0000);
    $display("test_refused done");
  endtask

  // Same word read on consecutive cycles keeps its value
  task automatic test_repeat();
    @(posedge mclk);
    cp_req_valid <= 1'b1;
    cp_is_read <= 1'b1;
    cp_opc1 <= 3'h0;
    cp_crn <= 4'h0;
    cp_crm <= 4'h2;
    cp_opc2 <= 3'h2;
    cp_priv_mode <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      if (i == 2) begin
        cp_req_valid <= 1'b0;
      end
      #1;
      `CHECK(cp_resp_valid, 1'b1)
      `CHECK(cp_rdata, 32'h1122_1011)
    end
    $display("test_repeat done");
  endtask

  // Neighbouring addresses are not claimed by the bank
  task automatic test_miss();
    do_access(1'b1, 3'h0, 4'h0, 4'h1, 3'h0, 1'b1, 1'b0, 1'b0, 32'h0000_0000);
    do_access(1'b1, 3'h0, 4'h1, 4'h2, 3'h0, 1'b1, 1'b0, 1'b0, 32'h0000_0000);
    do_access(1'b1, 3'h1, 4'h0, 4'h2, 3'h0, 1'b1, 1'b0, 1'b0, 32'h0000_0000);
    do_access(1'b0, 3'h0, 4'h0, 4'h3, 3'h0, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
    $display("test_miss done");
  endtask

  // Reset in mid-run silences the port but leaves the words unchanged
  task automatic test_reset();
    @(posedge mclk);
    reset_n <= 1'b0;
    cp_req_valid <= 1'b1;
    cp_is_read <= 1'b1;
    cp_opc1 <= 3'h0;
    cp_crn <= 4'h0;
    cp_crm <= 4'h2;
    cp_opc2 <= 3'h4;
    cp_priv_mode <= 1'b1;
    @(posedge mclk);
    @(posedge mclk);
    #1;
    `CHECK(cp_resp_valid, 1'b0)
    `CHECK(cp_rdata, 32'h0000_0000)
    // Request held across release is taken on the first edge seen high
    @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    `CHECK(cp_hit, 1'b0)
    @(posedge mclk);
    cp_req_valid <= 1'b0;
    #1;
    `CHECK(cp_resp_valid, 1'b1)
    `CHECK(cp_rdata, 32'h0000_0141)
    do_access(1'b1, 3'h0, 4'h0, 4'h2, 3'h4, 1'b1, 1'b1, 1'b0, 32'h0000_0141);
    do_access(1'b1, 3'h0, 4'h0, 4'h2, 3'h0, 1'b1, 1'b1, 1'b0, 32'h0010_0011);
    $display("test_reset done");
  endtask

  initial begin
    reset_n = 1'b0;
    cp_req_valid = 1'b0;
    cp_is_read = 1'b0;
    cp_opc1 = 3'h0;
    cp_crn = 4'h0;
    cp_crm = 4'h0;
    cp_opc2 = 3'h0;
    cp_priv_mode = 1'b0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    test_words();
    test_refused();
    test_repeat();
    test_miss();
    test_reset();
    complete_run();
  end

  // Tests need well under a thousand cycles
  initial begin
    #20us;
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
